// ### design/cfg_decode_pkg.sv
// Package: command codes, register field positions and carrier types for the mode register block
package cfg_decode_pkg;

    localparam int ADDR_W = 13;

    // Bank select encodings that pick the target register
    localparam logic [1:0] BANK_MODE      = 2'h0;
    localparam logic [1:0] BANK_EXT_ONE   = 2'h1;
    localparam logic [1:0] BANK_EXT_TWO   = 2'h2;
    localparam logic [1:0] BANK_EXT_THREE = 2'h3;

    // Command code {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_NOP       = 3'h7;

    // Mode register field positions
    localparam int MR_BL_LSB  = 0;
    localparam int MR_BT_BIT  = 3;
    localparam int MR_CL_LSB  = 4;
    localparam int MR_TM_BIT  = 7;
    localparam int MR_DLL_RST = 8;
    localparam int MR_WR_LSB  = 9;

    // Extended register one field positions
    localparam int E1_DLL_DIS  = 0;
    localparam int E1_DRV_BIT  = 1;
    localparam int E1_RTT_LO   = 2;
    localparam int E1_AL_LSB   = 3;
    localparam int E1_RTT_HI   = 6;
    localparam int E1_CAL_LSB  = 7;
    localparam int E1_DQSN_DIS = 10;
    localparam int E1_QOFF     = 12;

    // Reset values: contents are undefined after power-up, zero chosen
    localparam logic [ADDR_W-1:0] REG_RESET = 13'h0000;

    localparam logic [2:0] BL_FOUR  = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;

    // Whole-cycle latency codes accepted by the mode decode
    localparam logic [2:0] CL_MIN = 3'h2;
    localparam logic [2:0] CL_MAX = 3'h6;

    // Cycles the DLL needs to lock after a reset
    localparam int DLL_LOCK_CYCLES = 200;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [1:0]        bank;
        logic [ADDR_W-1:0] addr;
    } cmd_bus_t;

    typedef struct packed {
        logic [2:0] burst_len;
        logic       burst_interleave;
        logic [2:0] cas_latency;
        logic       test_mode;
        logic [2:0] write_recovery;
        logic       dll_enable;
        logic       drive_reduced;
        logic [1:0] termination_sel;
        logic [2:0] additive_latency;
        logic [2:0] calibration_mode;
        logic       strobe_n_disable;
        logic       output_off;
    } op_cfg_t;

endpackage : cfg_decode_pkg

// ### design/mode_register_block.sv
// Module: command decode and mode/extended register storage of the memory device
`timescale 1ns/1ps

// How it works
// (R1) Controller holds clock enable and termination_control low while powering up.
// (R2) Controller runs the clock stable for 200 us before leaving power-up.
// (R3) Controller presents NOP or deselect, then raises clock enable.
// (R4) Controller waits 400 ns of NOP after clock enable, then precharges all.
// (R5) Next comes a write to extended_config_two, bank bits 0 low, 1 high.
// (R6) Then a write to extended_config_three, both bank bits high.
// (R7) Then extended_config_one enables the DLL with bits 9..7 low.
// (R8) Then a mode register write with bit 8 high resets the DLL.
// (R9) Then precharge-all and at least two auto refresh commands.
// (R10) Then a mode register write with bit 8 low sets operating values.
// (R11) Driver calibration starts no earlier than 200 clocks after DLL reset.
// (R12) Without calibration, write calibration default then calibration exit to extended_config_one.
// (R13) Every write supplies all fields of the addressed register.
// (R14) Register writes and DLL reset never disturb array contents.
// (R15) Mode write decodes on all strobes low and bank bits zero.
// (R16) Mode register is undefined after power-up; controller must program it.
// (R17) Mode writes need all banks precharged, clock enable high, then mode_set_cycle_time.
// (R18) Mode fields: burst length, type, latency, test, DLL reset, write recovery.
// (R19) Half-clock latencies unsupported; test bit must be written low.
// (R20) Controller sets write recovery to ceiling of recovery time over clock period.
// (R21) extended_config_one written under same conditions and must be programmed at start.
// (R22) extended_config_one fields: DLL, drive strength, strobe disable, termination.
// (R23) Controller waits 200 clocks after DLL enable and reset before reading.
// (R24) Commands are ignored in any cycle with chip select high.
// (R25) Inputs sampled on rising clock, only while clock enable is registered high.
// (R26) Controller derives all waits from its own clock by counters.
module mode_register_block #(
    parameter int LOCK_CYCLES = cfg_decode_pkg::DLL_LOCK_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                                clk_sys,
    input  wire logic                                rst_b,
    input  wire logic                                clk_en,
    // Command pins, taken on the rising clock
    input  wire logic                                clock_enable_pin,
    input  cfg_decode_pkg::cmd_bus_t                 cmd,
    // Register contents
    output logic [cfg_decode_pkg::ADDR_W-1:0]        mode_reg,
    output logic [cfg_decode_pkg::ADDR_W-1:0]        extended_config_one,
    output logic [cfg_decode_pkg::ADDR_W-1:0]        extended_config_two,
    output logic [cfg_decode_pkg::ADDR_W-1:0]        extended_config_three,
    output cfg_decode_pkg::op_cfg_t                  op_cfg,
    // Status
    output logic                                     dll_locked,
    output logic                                     dll_reset_pulse,
    output logic                                     illegal_mode_write,
    output logic                                     mode_programmed
);

    localparam int CNT_W = $clog2(LOCK_CYCLES + 1);

    // Registered clock enable pin
    logic                              cke_q;
    logic                              next_cke_q;
    // Register file
    logic [cfg_decode_pkg::ADDR_W-1:0] next_mode_reg;
    logic [cfg_decode_pkg::ADDR_W-1:0] next_ext_one;
    logic [cfg_decode_pkg::ADDR_W-1:0] next_ext_two;
    logic [cfg_decode_pkg::ADDR_W-1:0] next_ext_three;
    logic                              next_programmed;
    // Decoded fields
    cfg_decode_pkg::op_cfg_t           next_op_cfg;
    // DLL lock timer
    logic [CNT_W-1:0]                  lock_cnt;
    logic [CNT_W-1:0]                  next_lock_cnt;
    logic                              next_dll_locked;
    // Status pulses
    logic                              next_dll_reset_pulse;
    logic                              next_illegal;
    // Decoded command strobes
    logic                              load_cmd;
    logic                              mode_write;
    logic                              dll_reset_cmd;
    logic                              dll_disable_cmd;

    // Mode write is legal only with burst 4 or 8, whole latency and test bit low
    function automatic logic mode_value_ok(input logic [cfg_decode_pkg::ADDR_W-1:0] v);
        logic [2:0] bl;
        logic [2:0] cl;
        bl = v[cfg_decode_pkg::MR_BL_LSB +: 3];
        cl = v[cfg_decode_pkg::MR_CL_LSB +: 3];
        return (bl == cfg_decode_pkg::BL_FOUR || bl == cfg_decode_pkg::BL_EIGHT)
            && (cl >= cfg_decode_pkg::CL_MIN) && (cl <= cfg_decode_pkg::CL_MAX)
            && !v[cfg_decode_pkg::MR_TM_BIT]; // (R19)
    endfunction : mode_value_ok

    // True when the sampled pins form a register load aimed at the given bank
    function automatic logic load_to(input logic                     cke,
                                     input cfg_decode_pkg::cmd_bus_t c,
                                     input logic [1:0]               bank);
        return cke && !c.cs_n
            && ({c.ras_n, c.cas_n, c.we_n} == cfg_decode_pkg::CMD_LOAD_MODE)
            && (c.bank == bank);
    endfunction : load_to

    // Commands only count while clock enable was registered high and chip select low
    assign load_cmd = cke_q && !cmd.cs_n // (R24) (R25)
                   && ({cmd.ras_n, cmd.cas_n, cmd.we_n} == cfg_decode_pkg::CMD_LOAD_MODE);
    assign mode_write      = load_to(cke_q, cmd, cfg_decode_pkg::BANK_MODE); // (R15)
    assign dll_reset_cmd   = mode_write && cmd.addr[cfg_decode_pkg::MR_DLL_RST]; // (R18)
    // Disabling the DLL drops lock at once, so a reader waits for a fresh lock
    assign dll_disable_cmd = load_to(cke_q, cmd, cfg_decode_pkg::BANK_EXT_ONE)
                          && cmd.addr[cfg_decode_pkg::E1_DLL_DIS]; // (R22)

    // Pin is registered, so a command counts only one edge after it rises
    always_comb begin
        next_cke_q = clock_enable_pin; // (R25)
    end

    // Register file: a load replaces the whole addressed word
    always_comb begin
        next_mode_reg   = mode_reg;
        next_ext_one    = extended_config_one;
        next_ext_two    = extended_config_two;
        next_ext_three  = extended_config_three;
        next_programmed = mode_programmed;
        if (load_cmd) begin
            // No partial update (R13)
            unique case (cmd.bank)
                cfg_decode_pkg::BANK_MODE: begin // (R15)
                    next_mode_reg   = cmd.addr;
                    next_programmed = 1'b1;
                end
                cfg_decode_pkg::BANK_EXT_ONE:   next_ext_one   = cmd.addr; // (R22)
                cfg_decode_pkg::BANK_EXT_TWO:   next_ext_two   = cmd.addr;
                cfg_decode_pkg::BANK_EXT_THREE: next_ext_three = cmd.addr;
            endcase
        end
    end

    // Lock timer runs every enabled cycle until lock while the DLL is enabled, other loads do not pause it
    always_comb begin
        next_lock_cnt   = lock_cnt;
        next_dll_locked = dll_locked;
        if (dll_reset_cmd || dll_disable_cmd) begin
            next_lock_cnt   = '0;
            next_dll_locked = 1'b0;
        end else if (!dll_locked && !extended_config_one[cfg_decode_pkg::E1_DLL_DIS]) begin
            if (lock_cnt == CNT_W'(LOCK_CYCLES - 1)) begin
                next_dll_locked = 1'b1;
            end else begin
                next_lock_cnt = lock_cnt + CNT_W'(1);
            end
        end
    end

    // Status pulses last one enabled cycle
    always_comb begin
        next_dll_reset_pulse = dll_reset_cmd;
        next_illegal         = mode_write && !mode_value_ok(cmd.addr); // (R19)
    end

    // Field split of the stored words, registered so outputs come from flops (R18) (R22)
    always_comb begin
        next_op_cfg.burst_len        = next_mode_reg[cfg_decode_pkg::MR_BL_LSB +: 3];
        next_op_cfg.burst_interleave = next_mode_reg[cfg_decode_pkg::MR_BT_BIT];
        next_op_cfg.cas_latency      = next_mode_reg[cfg_decode_pkg::MR_CL_LSB +: 3];
        next_op_cfg.test_mode        = next_mode_reg[cfg_decode_pkg::MR_TM_BIT];
        next_op_cfg.write_recovery   = next_mode_reg[cfg_decode_pkg::MR_WR_LSB +: 3];
        next_op_cfg.dll_enable       = !next_ext_one[cfg_decode_pkg::E1_DLL_DIS];
        next_op_cfg.drive_reduced    = next_ext_one[cfg_decode_pkg::E1_DRV_BIT];
        next_op_cfg.termination_sel  = {next_ext_one[cfg_decode_pkg::E1_RTT_HI],
                                        next_ext_one[cfg_decode_pkg::E1_RTT_LO]};
        next_op_cfg.additive_latency = next_ext_one[cfg_decode_pkg::E1_AL_LSB +: 3];
        next_op_cfg.calibration_mode = next_ext_one[cfg_decode_pkg::E1_CAL_LSB +: 3];
        next_op_cfg.strobe_n_disable = next_ext_one[cfg_decode_pkg::E1_DQSN_DIS];
        next_op_cfg.output_off       = next_ext_one[cfg_decode_pkg::E1_QOFF];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cke_q <= 1'b0;
        end else if (clk_en) begin
            cke_q <= next_cke_q;
        end
    end

    // No path here touches array storage, so reprogramming is safe at any time (R14)
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg              <= cfg_decode_pkg::REG_RESET;
            extended_config_one   <= cfg_decode_pkg::REG_RESET;
            extended_config_two   <= cfg_decode_pkg::REG_RESET;
            extended_config_three <= cfg_decode_pkg::REG_RESET;
            mode_programmed       <= 1'b0;
        end else if (clk_en) begin
            mode_reg              <= next_mode_reg;
            extended_config_one   <= next_ext_one;
            extended_config_two   <= next_ext_two;
            extended_config_three <= next_ext_three;
            mode_programmed       <= next_programmed;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_cfg <= '0;
        end else if (clk_en) begin
            op_cfg <= next_op_cfg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lock_cnt   <= '0;
            dll_locked <= 1'b0;
        end else if (clk_en) begin
            lock_cnt   <= next_lock_cnt;
            dll_locked <= next_dll_locked;
        end
    end

    // A frozen edge keeps a pulse up until the next enabled edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dll_reset_pulse    <= 1'b0;
            illegal_mode_write <= 1'b0;
        end else if (clk_en) begin
            dll_reset_pulse    <= next_dll_reset_pulse;
            illegal_mode_write <= next_illegal;
        end
    end

endmodule : mode_register_block

// ### verification/mode_register_block_chk.sv
// Checker: port-level properties of the mode register block
`timescale 1ns/1ps
module mode_register_block_chk (
    // Clock and control
    input wire logic                clk_sys,
    input wire logic                rst_b,
    input wire logic                clk_en,
    input wire logic                clock_enable_pin,
    input cfg_decode_pkg::cmd_bus_t cmd,
    // Observed state
    input wire logic [12:0]         mode_reg,
    input wire logic [12:0]         extended_config_one,
    input cfg_decode_pkg::op_cfg_t  op_cfg,
    input wire logic                dll_reset_pulse,
    input wire logic                illegal_mode_write,
    input wire logic                mode_programmed,
    input wire logic                dll_locked
);
    logic cke_q;
    logic next_cke_q;
    wire  bad = !(cmd.addr[2:0] inside {3'h2, 3'h3}) || cmd.addr[6:4] < 3'h2 || cmd.addr[6:4] > 3'h6 || cmd.addr[7];
    always_comb next_cke_q = clk_en ? clock_enable_pin : cke_q;
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            cke_q <= 1'b0;
        else
            cke_q <= next_cke_q;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence take(b);
        clk_en && cke_q && !cmd.cs_n && {cmd.ras_n, cmd.cas_n, cmd.we_n} == 3'h0 && cmd.bank == b;
    endsequence
    a_mode_store: assert property (take(2'h0) |=> mode_reg == $past(cmd.addr)) else $error("mode write lost");
    a_ext_store: assert property (take(2'h1) |=> extended_config_one == $past(cmd.addr)) else $error("ext write lost");
    a_mode_fields: assert property (take(2'h0) |=> op_cfg.burst_len == $past(cmd.addr[2:0])
        && op_cfg.burst_interleave == $past(cmd.addr[3]) && op_cfg.test_mode == $past(cmd.addr[7])
        && op_cfg.cas_latency == $past(cmd.addr[6:4]) && op_cfg.write_recovery == $past(cmd.addr[11:9]))
        else $error("mode fields wrong");
    a_ext_fields: assert property (take(2'h1) |=> op_cfg.dll_enable == !$past(cmd.addr[0])
        && op_cfg.drive_reduced == $past(cmd.addr[1])
        && op_cfg.termination_sel == $past({cmd.addr[6], cmd.addr[2]})
        && op_cfg.additive_latency == $past(cmd.addr[5:3]) && op_cfg.calibration_mode == $past(cmd.addr[9:7])
        && op_cfg.output_off == $past(cmd.addr[12])
        && op_cfg.strobe_n_disable == $past(cmd.addr[10])) else $error("ext fields wrong");
    a_dll_pulse: assert property (take(2'h0) |=> dll_reset_pulse == $past(cmd.addr[8])) else $error("dll pulse wrong");
    a_illegal_flag: assert property (take(2'h0) |=> illegal_mode_write == $past(bad)) else $error("flag wrong");
    a_mode_seen: assert property (take(2'h0) |=> mode_programmed) else $error("programmed low");
    a_deselect_held: assert property (clk_en && cmd.cs_n |=> $stable(mode_reg) && $stable(extended_config_one))
        else $error("deselect changed state");
    a_cke_gate: assert property ((!clk_en || !cke_q) |=> $stable(mode_reg) && $stable(extended_config_one))
        else $error("gated write landed");
    a_lock_clear: assert property (take(2'h1) && cmd.addr[0] |=> !dll_locked [*2]) else $error("lock kept");
endmodule : mode_register_block_chk
bind mode_register_block mode_register_block_chk u_chk (.clk_sys, .rst_b, .clk_en, .clock_enable_pin, .cmd,
    .mode_reg, .extended_config_one, .op_cfg, .dll_reset_pulse, .illegal_mode_write, .mode_programmed, .dll_locked);

// ### verification/ctrl_model.sv
// Partner: controller side driving clock enable and command pins
`timescale 1ns/1ps
module ctrl_model (
    // Clock
    input wire logic                 clk_sys,
    // Command pins
    output logic                     clock_enable_pin,
    output cfg_decode_pkg::cmd_bus_t cmd
);
    initial begin
        clock_enable_pin = 1'b0;
        cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
    end
    task automatic pin(input logic v);
        @(posedge clk_sys);
        clock_enable_pin <= v;
    endtask : pin
    // Deselected cycles flip the address so a stale value never looks held
    task automatic send(input cfg_decode_pkg::cmd_bus_t c);
        cfg_decode_pkg::cmd_bus_t n;
        n = c;
        if (c.cs_n) begin
            n.bank = ~cmd.bank;
            n.addr = ~cmd.addr;
        end
        @(posedge clk_sys);
        cmd <= n;
    endtask : send
endmodule : ctrl_model

// ### verification/mode_register_block_test.sv
// Testbench: init sequence, illegal modes and random commands
`timescale 1ns/1ps
module mode_register_block_test;
    typedef struct {int due; logic [1:0] b; logic [12:0] v; logic p; logic i;} note_t;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic clock_enable_pin;
    logic dll_locked, dll_reset_pulse, illegal_mode_write, mode_programmed;
    logic [12:0] mode_reg, extended_config_one, extended_config_two, extended_config_three;
    logic [12:0] shadow [4] = '{default: 13'h0000};
    logic [12:0] modes [6] = '{13'h00b2, 13'h0031, 13'h0072, 13'h0012, 13'h0033, 13'h0062};
    cfg_decode_pkg::cmd_bus_t cmd;
    cfg_decode_pkg::op_cfg_t op_cfg;
    note_t q[$];
    note_t n;
    int cyc = 0;
    int bad_count = 0;
    int comparisons = 0;
    bit live = 1'b0;
    integer seed = 32'hc3389cbe;
    logic [31:0] r;
    bit last_p = 1'b0;
    bit last_i = 1'b0;
    localparam int LOCK = 8;
    localparam int CLK_NS = 8;
    // Recovery time is an arbitrary bench value
    localparam int WR_NS = 15;
    localparam logic [2:0] WR_CYC = 3'((WR_NS + CLK_NS - 1) / CLK_NS);
    always #4 clk_sys = ~clk_sys;
    ctrl_model u_ctrl (.clk_sys(clk_sys), .clock_enable_pin(clock_enable_pin), .cmd(cmd));
    mode_register_block #(.LOCK_CYCLES(LOCK)) DUT (.clk_sys, .rst_b, .clk_en, .clock_enable_pin, .cmd, .mode_reg,
        .extended_config_one, .extended_config_two, .extended_config_three, .op_cfg, .dll_locked,
        .dll_reset_pulse, .illegal_mode_write, .mode_programmed);
    function automatic logic bad(input logic [12:0] a);
        return !(a[2:0] inside {3'h2, 3'h3}) || a[6:4] < 3'h2 || a[6:4] > 3'h6 || a[7];
    endfunction : bad
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic issue(input logic cs, input logic [2:0] c, input logic [1:0] b, input logic [12:0] a, input logic en);
        logic t;
        u_ctrl.send('{cs, c[2], c[1], c[0], b, a});
        clk_en <= en;
        t = en && live && !cs && c == 3'h0;
        if (t)
            shadow[b] = a;
        // A frozen edge keeps last cycle's pulses on the outputs
        if (en) begin
            last_p = t && b == 2'h0 && a[8];
            last_i = t && b == 2'h0 && bad(a);
        end
        q.push_back('{cyc + 2, b, shadow[b], last_p, last_i});
    endtask : issue
    task automatic rest(input int k);
        repeat (k) issue(1'b1, 3'h0, 2'h0, 13'h0000, 1'b1);
    endtask : rest
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    always @(negedge clk_sys) begin
        cyc = cyc + 1;
        while (q.size() > 0 && q[0].due == cyc) begin
            n = q.pop_front();
            check({n.b == 2'h0 ? mode_reg : n.b == 2'h1 ? extended_config_one : n.b == 2'h2 ? extended_config_two
                : extended_config_three, 1'b0, dll_reset_pulse, illegal_mode_write}, {n.v, 1'b0, n.p, n.i});
        end
    end
    initial begin
        #240000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        issue(1'b0, 3'h0, 2'h0, 13'h0132, 1'b1);
        repeat (25000) @(posedge clk_sys);
        u_ctrl.pin(1'b1);
        rest(50);
        live = 1'b1;
        issue(1'b0, cfg_decode_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
        issue(1'b0, 3'h0, 2'h2, 13'h0000, 1'b1);
        issue(1'b0, 3'h0, 2'h3, 13'h0000, 1'b1);
        issue(1'b0, 3'h0, 2'h1, 13'h0000, 1'b1);
        issue(1'b0, 3'h0, 2'h0, 13'h0132, 1'b1);
        issue(1'b0, cfg_decode_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 1'b1);
        repeat (2) issue(1'b0, cfg_decode_pkg::CMD_REFRESH, 2'h0, 13'h0000, 1'b1);
        issue(1'b0, 3'h0, 2'h0, {1'b0, WR_CYC, 9'h032}, 1'b1);
        rest(200);
        issue(1'b0, 3'h0, 2'h1, 13'h0380, 1'b1);
        issue(1'b0, 3'h0, 2'h1, 13'h0000, 1'b1);
        rest(4);
        @(negedge clk_sys);
        check({15'h0000, dll_locked}, 16'h0001);
        issue(1'b0, 3'h0, 2'h1, 13'h0001, 1'b1);
        rest(2);
        @(negedge clk_sys);
        check({15'h0000, dll_locked}, 16'h0000);
        issue(1'b0, 3'h0, 2'h1, 13'h1456, 1'b1);
        rest(2);
        @(negedge clk_sys);
        check({4'h0, op_cfg.drive_reduced, op_cfg.termination_sel, op_cfg.strobe_n_disable, op_cfg.output_off,
            op_cfg.additive_latency, op_cfg.calibration_mode, op_cfg.dll_enable}, 16'h0fa1);
        rest(LOCK - 2);
        @(negedge clk_sys);
        check({15'h0000, dll_locked}, 16'h0000);
        rest(1);
        @(negedge clk_sys);
        check({15'h0000, dll_locked}, 16'h0001);
        foreach (modes[i]) issue(1'b0, 3'h0, 2'h0, modes[i], 1'b1);
        issue(1'b1, 3'h0, 2'h0, 13'h1fff, 1'b1);
        issue(1'b0, 3'h0, 2'h0, 13'h1fff, 1'b0);
        repeat (300) begin
            r = $random(seed);
            issue(r[0] & r[1], r[2] ? 3'h0 : r[5:3], r[7:6], r[20:8], r[9] | r[10] | r[11]);
        end
        rest(3);
        end_sim();
    end
endmodule : mode_register_block_test
